//--- hw/ramv_consts.vh
`ifndef RAMV_CONSTS_VH
`define RAMV_CONSTS_VH
// ----------------------------------------------------------------
// Instruction kinds presented on i_kind
// ----------------------------------------------------------------
`define RAMV_KIND_W 3
`define RAMV_K_BRANCH 3'h0
`define RAMV_K_MOV_IMM_DIR 3'h1
`define RAMV_K_MOV_DIR_DIR 3'h2
`define RAMV_K_MOV_IX_DIR 3'h3
`define RAMV_K_MOV_DIR_IX 3'h4
`define RAMV_K_COMPARE_EQUAL_JUMP_IX 3'h5
`define RAMV_K_COMPARE_EQUAL_JUMP_IX1 3'h6
// ----------------------------------------------------------------
// Branch condition codes presented on i_cond
// ----------------------------------------------------------------
`define RAMV_COND_W 5
`define RAMV_C_ALWAYS 5'h00
`define RAMV_C_NEVER 5'h01
`define RAMV_C_HIGHER 5'h02
`define RAMV_C_LOWER_SAME 5'h03
`define RAMV_C_CARRY_CLR 5'h04
`define RAMV_C_CARRY_SET 5'h05
`define RAMV_C_NOT_EQUAL 5'h06
`define RAMV_C_EQUAL 5'h07
`define RAMV_C_HALF_CLR 5'h08
`define RAMV_C_HALF_SET 5'h09
`define RAMV_C_POSITIVE 5'h0A
`define RAMV_C_NEGATIVE 5'h0B
`define RAMV_C_MASK_CLR 5'h0C
`define RAMV_C_MASK_SET 5'h0D
`define RAMV_C_IRQ_LOW 5'h0E
`define RAMV_C_IRQ_HIGH 5'h0F
`define RAMV_C_SGE 5'h10
`define RAMV_C_SLT 5'h11
`define RAMV_C_SGT 5'h12
`define RAMV_C_SLE 5'h13
`define RAMV_C_BIT_CLR 5'h14
`define RAMV_C_BIT_SET 5'h15
`define RAMV_C_CALL 5'h16
// ----------------------------------------------------------------
// Instruction lengths in bytes and cycle counts
// ----------------------------------------------------------------
`define RAMV_LEN_REL 16'h0002
`define RAMV_LEN_3 16'h0003
`define RAMV_LEN_2 16'h0002
`define RAMV_CYC_IMM_DIR 3'h4
`define RAMV_CYC_DIR_DIR 3'h5
`define RAMV_CYC_IX_MOV 3'h4
// ----------------------------------------------------------------
// Reset values and direct page
// ----------------------------------------------------------------
`define RAMV_RST_PC 16'h0000
`define RAMV_RST_HX 16'h0000
`define RAMV_DIR_PAGE 8'h00
`endif

//--- hw/ramv_cond.v
`timescale 1ns/1ps
`default_nettype none
`include "ramv_consts.vh"
// Branch condition evaluator, purely combinational
module ramv_cond (
  input wire [4:0] i_cond, // Condition code
  input wire i_c, // Carry flag
  input wire i_z, // Zero flag
  input wire i_n, // Negative flag
  input wire i_v, // Overflow flag
  input wire i_h, // Half-carry flag
  input wire i_i, // Interrupt mask flag
  input wire i_irq, // Interrupt line level
  input wire i_bit, // Tested memory bit
  output reg o_take // Condition holds
);
  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  wire nxv;
  assign nxv = i_n ^ i_v;
  always @* begin
    o_take = 1'b0;
    case (i_cond)
      `RAMV_C_ALWAYS: o_take = 1'b1;
      `RAMV_C_CALL: o_take = 1'b1;
      `RAMV_C_NEVER: o_take = 1'b0;
      `RAMV_C_HIGHER: o_take = ~(i_c | i_z);
      `RAMV_C_LOWER_SAME: o_take = i_c | i_z;
      `RAMV_C_CARRY_CLR: o_take = ~i_c;
      `RAMV_C_CARRY_SET: o_take = i_c;
      `RAMV_C_NOT_EQUAL: o_take = ~i_z;
      `RAMV_C_EQUAL: o_take = i_z;
      `RAMV_C_HALF_CLR: o_take = ~i_h;
      `RAMV_C_HALF_SET: o_take = i_h;
      `RAMV_C_POSITIVE: o_take = ~i_n;
      `RAMV_C_NEGATIVE: o_take = i_n;
      `RAMV_C_MASK_CLR: o_take = ~i_i;
      `RAMV_C_MASK_SET: o_take = i_i;
      `RAMV_C_IRQ_LOW: o_take = ~i_irq;
      `RAMV_C_IRQ_HIGH: o_take = i_irq;
      `RAMV_C_SGE: o_take = ~nxv;
      `RAMV_C_SLT: o_take = nxv;
      `RAMV_C_SGT: o_take = ~(i_z | nxv);
      `RAMV_C_SLE: o_take = i_z | nxv;
      `RAMV_C_BIT_CLR: o_take = ~i_bit;
      `RAMV_C_BIT_SET: o_take = i_bit;
      default: o_take = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- hw/ramv_top.v
// What this block does
// - Conditional branches always use relative addressing
// - Target is opcode program counter plus 2 plus sign-extended offset
// - Taken loads target, else next instruction
// - Offset two's complement, -128 to +127
// - Signed branches use negative, zero, overflow
// - Signed conditions from Z and N xor V
// - Full relative branch condition set supported
// - Immediate-to-direct copy: 3 bytes, 4 cycles
// - Direct-to-direct copy: 3 bytes, 5 cycles
// - Indexed-to-direct copy, 2 bytes, 4 cycles, increment
// - Direct-to-indexed copy, 2 bytes, 4 cycles, increment
// - Copies never touch the accumulator
// - Index pair increments as one 16-bit value
// - Indexed no-offset post-increment is 2 bytes
// - Indexed offset post-increment: 3 bytes, unsigned offset
// - Compare-branch and copy use post-increment forms
`timescale 1ns/1ps
`default_nettype none
`include "ramv_consts.vh"
module ramv_top (
  input wire i_clk_sys, // System clock, 250 MHz
  input wire i_rst_n, // Asynchronous reset, active low
  input wire i_start, // Start one instruction, pulse
  input wire [2:0] i_kind, // Instruction kind
  input wire [4:0] i_cond, // Branch condition code
  input wire [15:0] i_pc, // Program counter at the opcode
  input wire [7:0] i_byte1, // First byte after the opcode
  input wire [7:0] i_byte2, // Second byte after the opcode
  input wire [15:0] i_hx, // Index pair at start
  input wire i_c, // Carry flag
  input wire i_z, // Zero flag
  input wire i_n, // Negative flag
  input wire i_v, // Overflow flag
  input wire i_h, // Half-carry flag
  input wire i_i, // Interrupt mask flag
  input wire i_irq, // Interrupt line level
  input wire i_bit, // Tested memory bit for bit branches
  input wire [7:0] i_rdata, // Memory read data, valid next cycle
  input wire [7:0] i_acc, // Accumulator in
  output reg [15:0] o_addr, // Memory address
  output reg o_rd, // Memory read strobe
  output reg o_wr, // Memory write strobe
  output reg [7:0] o_wdata, // Memory write data
  output reg [15:0] o_ea, // Effective address of operand or target
  output reg [15:0] o_pc, // Next program counter
  output reg [15:0] o_hx, // Index pair after the instruction
  output reg [7:0] o_acc, // Accumulator out, never changed here
  output reg o_taken, // Branch taken
  output reg o_done, // Instruction finished, pulse
  output wire o_busy // Sequencer busy
);
  // --------------------------------------------------------------
  // States, one-hot
  // --------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h1; // Waiting for start
  localparam [3:0] S_RUN = 4'h2; // Counting cycles
  localparam [3:0] S_RD = 4'h4; // Source read issued
  localparam [3:0] S_WR = 4'h8; // Destination write
  // --------------------------------------------------------------
  // Working registers
  // --------------------------------------------------------------
  reg [3:0] state_reg; // Current state
  reg [2:0] cnt_reg; // Cycles remaining
  reg [2:0] kind_reg; // Latched kind
  reg [7:0] dst_reg; // Latched direct destination
  // --------------------------------------------------------------
  // Combinational results
  // --------------------------------------------------------------
  wire take; // Condition result
  wire [15:0] next_pc; // Address after the instruction
  wire [15:0] rel_tgt; // Relative destination
  wire [15:0] hx_inc; // Incremented index pair
  wire [15:0] len; // Instruction length
  // Busy whenever the sequencer has left idle
  assign o_busy = ~state_reg[0];
  // --------------------------------------------------------------
  // Address arithmetic
  // --------------------------------------------------------------
  // Branches and no-offset indexed forms are two bytes long
  assign len = (i_kind == `RAMV_K_BRANCH) ? `RAMV_LEN_REL :
               (i_kind == `RAMV_K_MOV_IX_DIR || i_kind == `RAMV_K_MOV_DIR_IX ||
                i_kind == `RAMV_K_COMPARE_EQUAL_JUMP_IX) ? `RAMV_LEN_2 : `RAMV_LEN_3;
  assign next_pc = i_pc + len;
  // Offset sign-extended, measured from the next location
  assign rel_tgt = next_pc + {{8{i_byte1[7]}}, i_byte1};
  assign hx_inc = i_hx + 16'h0001;
  // --------------------------------------------------------------
  // Condition decode
  // --------------------------------------------------------------
  // Flags and pin levels are judged in the cycle of the start pulse
  ramv_cond i_ramv_cond (
    .i_cond(i_cond),
    .i_c(i_c),
    .i_z(i_z),
    .i_n(i_n),
    .i_v(i_v),
    .i_h(i_h),
    .i_i(i_i),
    .i_irq(i_irq),
    .i_bit(i_bit),
    .o_take(take)
  );
  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  // One instruction at a time: issue in idle, then read and write for sourced copies, and pad for every copy.
  // Every copy occupies exactly its cycle count from start to next start.
  // Strobes and done are one-cycle pulses, cleared by default each cycle.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Everything idle and zero
      state_reg <= S_IDLE;
      cnt_reg <= 3'h0;
      kind_reg <= 3'h0;
      dst_reg <= 8'h00;
      o_addr <= 16'h0000;
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      o_wdata <= 8'h00;
      o_ea <= 16'h0000;
      o_pc <= `RAMV_RST_PC;
      o_hx <= `RAMV_RST_HX;
      o_acc <= 8'h00;
      o_taken <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      o_done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (i_start) begin
            // Latch what every kind needs
            kind_reg <= i_kind;
            o_acc <= i_acc;
            o_hx <= i_hx;
            o_taken <= 1'b0;
            o_pc <= next_pc;
            if (i_kind == `RAMV_K_BRANCH) begin
              // Branch resolved at once, every conditional branch is relative
              o_ea <= rel_tgt;
              o_taken <= take;
              o_pc <= take ? rel_tgt : next_pc;
              o_done <= 1'b1;
            end else if (i_kind == `RAMV_K_MOV_IMM_DIR) begin
              // Immediate byte straight to direct page
              o_addr <= {`RAMV_DIR_PAGE, i_byte2};
              o_ea <= {`RAMV_DIR_PAGE, i_byte2};
              o_wdata <= i_byte1;
              o_wr <= 1'b1;
              // Issue cycle plus three counted cycles makes four
              cnt_reg <= `RAMV_CYC_IMM_DIR - 3'h1;
              state_reg <= S_RUN;
            end else if (i_kind == `RAMV_K_MOV_DIR_DIR) begin
              // Read the source byte, keep the destination for later
              o_addr <= {`RAMV_DIR_PAGE, i_byte1};
              o_ea <= {`RAMV_DIR_PAGE, i_byte1};
              o_rd <= 1'b1;
              dst_reg <= i_byte2;
              // Issue, read and write cycles, then two counted cycles
              cnt_reg <= `RAMV_CYC_DIR_DIR - 3'h3;
              state_reg <= S_RD;
            end else if (i_kind == `RAMV_K_MOV_IX_DIR) begin
              // Read through the index pair and advance it at once
              o_addr <= i_hx;
              o_ea <= i_hx;
              o_rd <= 1'b1;
              dst_reg <= i_byte1;
              o_hx <= hx_inc;
              cnt_reg <= `RAMV_CYC_IX_MOV - 3'h3;
              state_reg <= S_RD;
            end else if (i_kind == `RAMV_K_MOV_DIR_IX) begin
              // Read the direct source; the write goes to the old index
              o_addr <= {`RAMV_DIR_PAGE, i_byte1};
              o_ea <= {`RAMV_DIR_PAGE, i_byte1};
              o_rd <= 1'b1;
              o_hx <= hx_inc;
              cnt_reg <= `RAMV_CYC_IX_MOV - 3'h3;
              state_reg <= S_RD;
            end else begin
              // Compare-branch operand address, index then post-increment
              if (i_kind == `RAMV_K_COMPARE_EQUAL_JUMP_IX1) begin
                o_ea <= i_hx + {8'h00, i_byte1};
              end else begin
                o_ea <= i_hx;
              end
              o_hx <= hx_inc;
              o_done <= 1'b1;
            end
          end
        end
        S_RD: begin
          // Read strobe cycle is over; memory answers in the next one
          state_reg <= S_WR;
        end
        S_WR: begin
          // Source byte stands on the read bus now, forward it untouched
          o_wdata <= i_rdata;
          o_wr <= 1'b1;
          if (kind_reg == `RAMV_K_MOV_DIR_IX) begin
            o_addr <= o_hx - 16'h0001;
          end else begin
            o_addr <= {`RAMV_DIR_PAGE, dst_reg};
          end
          state_reg <= S_RUN;
        end
        S_RUN: begin
          // Pad to the documented cycle count
          if (cnt_reg <= 3'h1) begin
            o_done <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        // Illegal one-hot code, recover to idle
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- sim/ramv_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ramv_consts.vh"
// Sequencer checker
module ramv_sva (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_start, // Start pulse
  input wire logic [2:0] i_kind, // Kind
  input wire logic [4:0] i_cond, // Condition
  input wire logic [15:0] i_pc, // Opcode address
  input wire logic [7:0] i_byte1, // Byte 1
  input wire logic [7:0] i_byte2, // Byte 2
  input wire logic [15:0] i_hx, // Index pair
  input wire logic i_z, // Zero
  input wire logic i_n, // Negative
  input wire logic i_v, // Overflow
  input wire logic [7:0] i_acc, // Accumulator in
  input wire logic [15:0] o_addr, // Address
  input wire logic o_rd, // Read strobe
  input wire logic o_wr, // Write strobe
  input wire logic [7:0] o_wdata, // Write data
  input wire logic [15:0] o_ea, // Target
  input wire logic [15:0] o_pc, // Next pc
  input wire logic [15:0] o_hx, // Index out
  input wire logic [7:0] o_acc, // Accumulator out
  input wire logic o_taken, // Taken
  input wire logic o_done, // Done
  input wire logic o_busy // Busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire go = i_start && !o_busy;
  wire br = go && i_kind == `RAMV_K_BRANCH;
  wire sx = i_n ^ i_v;
  wire [15:0] nxt = i_pc + 16'h0002;
  wire [15:0] tgt = nxt + {{8{i_byte1[7]}}, i_byte1};
  reg [2:0] kq;
  reg [15:0] hq;
  // Kind and index pair of the running instruction
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kq <= 3'h0;
      hq <= 16'h0000;
    end else if (go) begin
      kq <= i_kind;
      hq <= i_hx;
    end
  end
  sequence s_dir_rd; o_rd && o_addr == {8'h00, $past(i_byte1)}; endsequence
  sequence s_imm_wr; o_wr && o_addr == {8'h00, $past(i_byte2)} && o_wdata == $past(i_byte1);
  endsequence
  sequence s_dd_wr; o_wr && o_addr == {8'h00, $past(i_byte2, 3)}; endsequence
  property p_target; br |=> o_done && o_ea == $past(tgt); endproperty
  property p_next; br |=> o_pc == (o_taken ? o_ea : $past(nxt)); endproperty
  property p_never; br && i_cond == `RAMV_C_NEVER |=> !o_taken; endproperty
  property p_always; br && i_cond == `RAMV_C_ALWAYS |=> o_taken; endproperty
  property p_sge; br && i_cond == `RAMV_C_SGE |=> o_taken == !$past(sx); endproperty
  property p_sgt; br && i_cond == `RAMV_C_SGT |=> o_taken == !($past(i_z) | $past(sx)); endproperty
  property p_imm; go && i_kind == `RAMV_K_MOV_IMM_DIR |=> s_imm_wr ##3 o_done; endproperty
  property p_dd; go && i_kind == `RAMV_K_MOV_DIR_DIR |=> s_dir_rd ##2 s_dd_wr ##2 o_done;
  endproperty
  property p_ixcyc;
    go && (i_kind == `RAMV_K_MOV_IX_DIR || i_kind == `RAMV_K_MOV_DIR_IX) |=>
      o_rd ##2 o_wr ##1 o_done;
  endproperty
  property p_ixrd; go && i_kind == `RAMV_K_MOV_IX_DIR |=> o_rd && o_addr == $past(i_hx); endproperty
  property p_acc; go |=> o_acc == $past(i_acc); endproperty
  property p_hx; o_done && kq > 3'h2 |-> o_hx == hq + 16'h0001; endproperty
  a_target: assert property (p_target) else $error("bad branch target");
  a_next: assert property (p_next) else $error("bad next pc");
  a_never: assert property (p_never) else $error("never branch taken");
  a_always: assert property (p_always) else $error("always branch skipped");
  a_sge: assert property (p_sge) else $error("signed ge wrong");
  a_sgt: assert property (p_sgt) else $error("signed gt wrong");
  a_imm: assert property (p_imm) else $error("imm copy wrong");
  a_dd: assert property (p_dd) else $error("dir copy wrong");
  a_ixrd: assert property (p_ixrd) else $error("index read wrong");
  a_ixcyc: assert property (p_ixcyc) else $error("index copy timing wrong");
  a_acc: assert property (p_acc) else $error("accumulator changed");
  a_hx: assert property (p_hx) else $error("index not advanced");
endmodule
bind ramv_top ramv_sva i_ramv_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start),
  .i_kind(i_kind), .i_cond(i_cond), .i_pc(i_pc), .i_byte1(i_byte1), .i_byte2(i_byte2),
  .i_hx(i_hx), .i_z(i_z), .i_n(i_n), .i_v(i_v), .i_acc(i_acc), .o_addr(o_addr), .o_rd(o_rd),
  .o_wr(o_wr), .o_wdata(o_wdata), .o_ea(o_ea), .o_pc(o_pc), .o_hx(o_hx), .o_acc(o_acc),
  .o_taken(o_taken), .o_done(o_done), .o_busy(o_busy));
`default_nettype wire

//--- sim/ramv_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Memory on the far side of the bus
module ramv_mem (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rd, // Read strobe
  input wire logic i_wr, // Write strobe
  input wire logic [15:0] i_addr, // Address
  input wire logic [7:0] i_wdata, // Write data
  output logic [7:0] o_rdata // Read data
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = a[7:0] ^ a[15:8] ^ 8'hA5;
    o_rdata = 8'h00;
  end
  // Data valid one cycle after the strobe, scrambled otherwise
  always @(posedge i_clk_sys) begin
    if (i_wr) mem[i_addr] <= i_wdata;
    if (i_rd) o_rdata <= mem[i_addr];
    else o_rdata <= ~o_rdata;
  end
endmodule
`default_nettype wire

//--- sim/ramv_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ramv_top_tb;
  typedef struct packed {logic [2:0] k; logic [15:0] pc, hx, ea; logic [7:0] acc; logic tk;} ramv_exp_t;
  logic clk, rst_n, st, rd, wr, tk, done, busy;
  logic [2:0] kind;
  logic [4:0] cond;
  logic [7:0] b1, b2, fl, acc, rdata, wdata, oacc;
  logic [15:0] pc, hx, addr, ea, opc, ohx;
  ramv_exp_t qd[$];
  logic [23:0] qw[$];
  int n_tests = 0;
  int fail_count = 0;
  ramv_top i_ramv_top (.i_clk_sys(clk), .i_rst_n(rst_n), .i_start(st), .i_kind(kind),
    .i_cond(cond), .i_pc(pc), .i_byte1(b1), .i_byte2(b2), .i_hx(hx), .i_c(fl[0]), .i_z(fl[1]),
    .i_n(fl[2]), .i_v(fl[3]), .i_h(fl[4]), .i_i(fl[5]), .i_irq(fl[6]), .i_bit(fl[7]),
    .i_rdata(rdata), .i_acc(acc), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata),
    .o_ea(ea), .o_pc(opc), .o_hx(ohx), .o_acc(oacc), .o_taken(tk), .o_done(done), .o_busy(busy));
  ramv_mem i_ramv_mem (.i_clk_sys(clk), .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Branch decision from condition code and flags
  function automatic logic take(input logic [4:0] c, input logic [7:0] f);
    logic [11:0] b;
    b = {1'b0, f[7], f[1] | (f[2] ^ f[3]), f[2] ^ f[3], f[6], f[5], f[2], f[4], f[1], f[0],
      f[0] | f[1], 1'b0};
    return c[0] ? b[c[4:1]] : !b[c[4:1]];
  endfunction
  function automatic logic [7:0] mv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  // One instruction; spam retries start while busy
  task run(input logic [2:0] k, input logic [4:0] c, input logic [15:0] p, input logic [7:0] x1,
    input logic [7:0] x2, input logic [15:0] h, input logic [7:0] f, input logic spam);
    ramv_exp_t e;
    int n;
    e.k = k;
    e.tk = take(c, f);
    e.pc = (k == 3'h1 || k == 3'h2 || k == 3'h6) ? p + 16'h0003 : p + 16'h0002;
    if (k == 3'h0 && e.tk) e.pc = e.pc + {{8{x1[7]}}, x1};
    e.hx = h + 16'h0001;
    e.ea = (k == 3'h6) ? h + {8'h00, x1} : h;
    case (k)
      3'h1: qw.push_back({8'h00, x2, x1});
      3'h2: qw.push_back({8'h00, x2, mv({8'h00, x1})});
      3'h3: qw.push_back({8'h00, x1, mv(h)});
      3'h4: qw.push_back({h, mv({8'h00, x1})});
      default: ;
    endcase
    @(posedge clk);
    #1;
    {st, kind, cond, pc, b1, b2, hx, fl} = {1'b1, k, c, p, x1, x2, h, f};
    acc = 8'($urandom);
    e.acc = acc;
    qd.push_back(e);
    @(posedge clk);
    #1;
    st = spam;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      st = 0;
      n++;
    end
    if (n == 20) chk("done", 16'h0, 16'h1);
  endtask
  // Result monitor
  always @(posedge clk) begin
    ramv_exp_t e;
    logic [23:0] w;
    if (rst_n && done === 1'b1) begin
      if (qd.size() == 0) chk("extra done", 16'h1, 16'h0);
      else begin
        e = qd.pop_front();
        chk("acc", oacc, e.acc);
        if (e.k == 3'h0) chk("pc", opc, e.pc);
        if (e.k != 3'h0) chk("len", opc, e.pc);
        chk("busy", {15'h0, busy}, 16'h0);
        if (e.k == 3'h0) chk("taken", tk, e.tk);
        if (e.k > 3'h2) chk("hx", ohx, e.hx);
        if (e.k > 3'h4) chk("ea", ea, e.ea);
      end
    end
    if (rst_n && wr === 1'b1) begin
      chk("write", 16'(qw.size()), 16'h1);
      if (qw.size() != 0) begin
        w = qw.pop_front();
        chk("waddr", addr, w[23:8]);
        chk("wdata", {8'h00, wdata}, {8'h00, w[7:0]});
      end
    end
  end
  initial begin
    #200000;
    fail_count++;
    end_sim;
  end
  initial begin
    {rst_n, st, kind, cond, pc, b1, b2, hx, fl, acc} = '0;
    void'($urandom(58054));
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    run(3'h0, 5'h00, 16'h1000, 8'h7F, 8'h00, 16'h0, 8'h00, 0);
    run(3'h0, 5'h00, 16'h0010, 8'h80, 8'h00, 16'h0, 8'h00, 0);
    for (int i = 0; i < 200; i++)
      run(3'h0, 5'($urandom % 23), 16'($urandom), 8'($urandom), 8'h0, 16'h0, 8'($urandom), 0);
    $display("branch test done");
    run(3'h3, 5'h0, 16'h0, 8'h90, 8'h0, 16'h01FF, 8'h0, 1);
    run(3'h4, 5'h0, 16'h0, 8'h11, 8'h0, 16'hFFFF, 8'h0, 1);
    for (int i = 0; i < 20; i++) begin
      run(3'h1, 5'h0, 16'h0, 8'($urandom), 8'h80 | 8'($urandom), 16'h0, 8'h0, i == 0);
      run(3'h2, 5'h0, 16'h0, 8'h7F & 8'($urandom), 8'h80 | 8'($urandom), 16'h0, 8'h0, i == 0);
      run(3'h3, 5'h0, 16'h0, 8'h80 | 8'($urandom), 8'h0, 16'h0100 + 16'($urandom % 32512),
        8'h0, 0);
      run(3'h4, 5'h0, 16'h0, 8'h7F & 8'($urandom), 8'h0, 16'h8000 | 16'($urandom), 8'h0, 0);
      run(3'h5, 5'h0, 16'h0, 8'($urandom), 8'h0, 16'($urandom), 8'h0, 0);
      run(3'h6, 5'h0, 16'h0, 8'($urandom), 8'h0, (i == 0) ? 16'hFFFF : 16'($urandom), 8'h0, 0);
    end
    $display("copy test done");
    repeat (3) @(posedge clk);
    end_sim;
  end
endmodule
`default_nettype wire
